// ---- hw/channel_clock_dividers.sv ----
/*
 * Channel clock dividers: two single-stage channels and two cascaded
 * channels with split single-ended outputs, plus an Avalon-MM slave.
 * Assumes distClkIn is the selected distribution clock sampled
 * synchronously to core_clk, and syncPulse is a one-cycle pulse.
 */
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "chan_div_map.svh"

// one divider stage: counts input rising edges, optional half-cycle fix
module div_stage
	import chan_div_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic inLvl,
	input wire logic inRise,
	input wire logic inFall,
	input wire logic bypass,
	input wire logic [3:0] lowCnt,
	input wire logic [3:0] highCnt,
	input wire logic dccOn,
	input wire logic syncReq,
	input wire logic [4:0] delayCyc,
	output logic outLvl,
	output logic outRise,
	output logic outFall
);
	stage_state_t state_q, state_d;
	logic [4:0] cnt_q, cnt_d;
	logic out_q, out_d;
	logic prev_q;
	logic fallPend_q, fallPend_d;
	logic oddFix;

	// odd ratio set as low = high + 1 is corrected by a late fall
	assign oddFix = dccOn && ({1'b0, lowCnt} == {1'b0, highCnt} + 5'h01);

	// next-state: wait out the offset, then high and low phases
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		out_d = out_q;
		fallPend_d = fallPend_q;
		if (syncReq) begin
			state_d = ST_WAIT;
			cnt_d = delayCyc;
			out_d = 1'b0;
			fallPend_d = 1'b0;
		end else if (bypass) begin
			out_d = inLvl;
		end else begin
			if (fallPend_q && inFall) begin
				out_d = 1'b0; // half cycle later high to low
				fallPend_d = 1'b0;
			end
			if (inRise) begin
				case (state_q)
					ST_WAIT: begin
						if (cnt_q == 5'h00) begin
							state_d = ST_HIGH;
							cnt_d = {1'b0, highCnt};
							out_d = 1'b1;
						end else begin
							cnt_d = cnt_q - 5'h01;
						end
					end
					ST_HIGH: begin
						if (cnt_q == 5'h00) begin
							state_d = ST_LOW;
							cnt_d = {1'b0, lowCnt};
							if (oddFix) begin
								fallPend_d = 1'b1;
							end else begin
								out_d = 1'b0;
							end
						end else begin
							cnt_d = cnt_q - 5'h01;
						end
					end
					ST_LOW: begin
						if (cnt_q == 5'h00) begin
							state_d = ST_HIGH;
							cnt_d = {1'b0, highCnt};
							out_d = 1'b1;
							fallPend_d = 1'b0;
						end else begin
							cnt_d = cnt_q - 5'h01;
						end
					end
					default: begin
						state_d = ST_WAIT;
						cnt_d = 5'h00;
					end
				endcase
			end
		end
	end

	// stage registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_WAIT;
			cnt_q <= 5'h00;
			out_q <= 1'b0;
			prev_q <= 1'b0;
			fallPend_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			out_q <= out_d;
			prev_q <= out_q;
			fallPend_q <= fallPend_d;
		end
	end

	// output level and its edges for a following stage
	assign outLvl = out_q;
	assign outRise = out_q & ~prev_q;
	assign outFall = ~out_q & prev_q;
endmodule // div_stage

// Function
// - rising edge delayed by counted input edges
// - offset is start-high weight 16 plus phase
// - offset above 15 adds low count plus one
// - offsets apply only at a synchronization event
// - cascaded outputs split to A/B, B off
// - cascaded channels multiply two 2-to-32 stages
// - each cascaded stage has its own bypass
// - low count bits 7:4, high bits 3:0
// - phases last stored count plus one cycle
// - ratio is stage sum or product of sums
// - duty correction on at reset, one disable
// - VCO-divided bypass passes its uneven duty
// - bypass passes input duty, else high fraction
// - single-stage channels: bypass bit7, disable next register
module channel_clock_dividers
	import chan_div_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic distClkIn,
	input wire logic syncPulse,
	input wire logic [10:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	output logic ch0Out,
	output logic ch1Out,
	output logic ch2Out,
	output logic ch2OutA,
	output logic ch2OutB,
	output logic ch3Out,
	output logic ch3OutA,
	output logic ch3OutB
);
	reg8_t ch0Counts_q, ch0Phase_q, ch0Fix_q;
	reg8_t ch1Counts_q, ch1Phase_q, ch1Fix_q;
	reg8_t ch2S1_q, ch2S2_q, ch2Byp_q, ch2Fix_q;
	reg8_t ch3S1_q, ch3S2_q, ch3Byp_q, ch3Fix_q;
	reg8_t outEn_q;
	logic ack_q;
	logic [31:0] rdData_q;
	logic swSync_q;
	logic dist_q, distPrev_q;
	logic [8:0] regIdx;
	logic busReq, wrStrobe, mapped, wrLane0;
	reg8_t rdByte;
	logic syncAll, inRise, inFall;
	logic [4:0] delay0, delay1;
	logic s21Lvl, s21Rise, s21Fall, s31Lvl, s31Rise, s31Fall;
	logic c0Lvl, c1Lvl, c2Lvl, c3Lvl;
	logic [3:0] statusBits;

	// bus decode; offsets are indices, so the word address is the index
	assign regIdx = avsAddress[10:2];
	assign busReq = avsRead | avsWrite;
	assign avsWaitRequest = busReq & ~ack_q;
	assign wrStrobe = avsWrite & ack_q;
	assign wrLane0 = avsByteEnable[0];
	assign avsReadData = rdData_q;

	// read selection of the addressed register
	assign mapped = (regIdx == `IDX_CH0_CYCLE_COUNTS) || (regIdx == `IDX_CH0_PHASE_SETUP)
		|| (regIdx == `IDX_CH0_DUTY_FIX) || (regIdx == `IDX_CH1_CYCLE_COUNTS)
		|| (regIdx == `IDX_CH1_PHASE_SETUP) || (regIdx == `IDX_CH1_DUTY_FIX)
		|| (regIdx == `IDX_CH2_STAGE1_COUNTS) || (regIdx == `IDX_CH2_STAGE2_COUNTS)
		|| (regIdx == `IDX_CH2_BYPASS_CTRL) || (regIdx == `IDX_CH2_DUTY_FIX_CTRL)
		|| (regIdx == `IDX_CH3_STAGE1_COUNTS) || (regIdx == `IDX_CH3_STAGE2_COUNTS)
		|| (regIdx == `IDX_CH3_BYPASS_CTRL) || (regIdx == `IDX_CH3_DUTY_FIX_CTRL)
		|| (regIdx == `IDX_OUT_ENABLE) || (regIdx == `IDX_STATUS)
		|| (regIdx == `IDX_SYNC_CTRL);
	assign rdByte = (regIdx == `IDX_CH0_CYCLE_COUNTS) ? ch0Counts_q :
		(regIdx == `IDX_CH0_PHASE_SETUP) ? ch0Phase_q :
		(regIdx == `IDX_CH0_DUTY_FIX) ? ch0Fix_q :
		(regIdx == `IDX_CH1_CYCLE_COUNTS) ? ch1Counts_q :
		(regIdx == `IDX_CH1_PHASE_SETUP) ? ch1Phase_q :
		(regIdx == `IDX_CH1_DUTY_FIX) ? ch1Fix_q :
		(regIdx == `IDX_CH2_STAGE1_COUNTS) ? ch2S1_q :
		(regIdx == `IDX_CH2_STAGE2_COUNTS) ? ch2S2_q :
		(regIdx == `IDX_CH2_BYPASS_CTRL) ? ch2Byp_q :
		(regIdx == `IDX_CH2_DUTY_FIX_CTRL) ? ch2Fix_q :
		(regIdx == `IDX_CH3_STAGE1_COUNTS) ? ch3S1_q :
		(regIdx == `IDX_CH3_STAGE2_COUNTS) ? ch3S2_q :
		(regIdx == `IDX_CH3_BYPASS_CTRL) ? ch3Byp_q :
		(regIdx == `IDX_CH3_DUTY_FIX_CTRL) ? ch3Fix_q :
		(regIdx == `IDX_OUT_ENABLE) ? outEn_q :
		(regIdx == `IDX_STATUS) ? {4'h0, statusBits} :
		`RST_REG8;

	// one wait cycle per access; read data latched as the wait ends
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
			rdData_q <= `UNMAPPED_DATA;
		end else begin
			ack_q <= busReq & ~ack_q;
			if (avsRead && !ack_q) begin
				rdData_q <= mapped ? {24'h000000, rdByte} : `UNMAPPED_DATA;
			end
		end
	end

	// configuration registers; only byte lane 0 carries data
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ch0Counts_q <= `RST_REG8;
			ch0Phase_q <= `RST_REG8;
			ch0Fix_q <= `RST_REG8;
			ch1Counts_q <= `RST_REG8;
			ch1Phase_q <= `RST_REG8;
			ch1Fix_q <= `RST_REG8;
			ch2S1_q <= `RST_REG8;
			ch2S2_q <= `RST_REG8;
			ch2Byp_q <= `RST_REG8;
			ch2Fix_q <= `RST_REG8;
			ch3S1_q <= `RST_REG8;
			ch3S2_q <= `RST_REG8;
			ch3Byp_q <= `RST_REG8;
			ch3Fix_q <= `RST_REG8;
			outEn_q <= `RST_REG8;
		end else if (wrStrobe && wrLane0) begin
			case (regIdx)
				`IDX_CH0_CYCLE_COUNTS: ch0Counts_q <= avsWriteData[7:0];
				`IDX_CH0_PHASE_SETUP: ch0Phase_q <= avsWriteData[7:0];
				`IDX_CH0_DUTY_FIX: ch0Fix_q <= avsWriteData[7:0];
				`IDX_CH1_CYCLE_COUNTS: ch1Counts_q <= avsWriteData[7:0];
				`IDX_CH1_PHASE_SETUP: ch1Phase_q <= avsWriteData[7:0];
				`IDX_CH1_DUTY_FIX: ch1Fix_q <= avsWriteData[7:0];
				`IDX_CH2_STAGE1_COUNTS: ch2S1_q <= avsWriteData[7:0];
				`IDX_CH2_STAGE2_COUNTS: ch2S2_q <= avsWriteData[7:0];
				`IDX_CH2_BYPASS_CTRL: ch2Byp_q <= avsWriteData[7:0];
				`IDX_CH2_DUTY_FIX_CTRL: ch2Fix_q <= avsWriteData[7:0];
				`IDX_CH3_STAGE1_COUNTS: ch3S1_q <= avsWriteData[7:0];
				`IDX_CH3_STAGE2_COUNTS: ch3S2_q <= avsWriteData[7:0];
				`IDX_CH3_BYPASS_CTRL: ch3Byp_q <= avsWriteData[7:0];
				`IDX_CH3_DUTY_FIX_CTRL: ch3Fix_q <= avsWriteData[7:0];
				`IDX_OUT_ENABLE: outEn_q <= avsWriteData[7:0];
				default: ;
			endcase
		end
	end

	// software sync request, a single pulse per write of the go bit
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			swSync_q <= 1'b0;
		end else begin
			swSync_q <= wrStrobe & wrLane0 & (regIdx == `IDX_SYNC_CTRL)
				& avsWriteData[`BIT_SYNC_GO];
		end
	end
	assign syncAll = syncPulse | swSync_q;

	// edges of the distribution clock
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dist_q <= 1'b0;
			distPrev_q <= 1'b0;
		end else begin
			dist_q <= distClkIn;
			distPrev_q <= dist_q;
		end
	end
	assign inRise = dist_q & ~distPrev_q;
	assign inFall = ~dist_q & distPrev_q;

	// coarse offset: start-high weight 16 adds low count plus one
	assign delay0 = ch0Phase_q[`BIT_START_HIGH] ?
		({1'b0, ch0Phase_q[`PO_MSB:`PO_LSB]} + {1'b0, ch0Counts_q[`LOW_MSB:`LOW_LSB]}
		+ 5'h01) : {1'b0, ch0Phase_q[`PO_MSB:`PO_LSB]};
	assign delay1 = ch1Phase_q[`BIT_START_HIGH] ?
		({1'b0, ch1Phase_q[`PO_MSB:`PO_LSB]} + {1'b0, ch1Counts_q[`LOW_MSB:`LOW_LSB]}
		+ 5'h01) : {1'b0, ch1Phase_q[`PO_MSB:`PO_LSB]};

	// channel 0 single stage
	div_stage u_ch0 (
		.core_clk(core_clk), .resetn(resetn),
		.inLvl(dist_q), .inRise(inRise), .inFall(inFall),
		.bypass(ch0Phase_q[`BIT_CH01_BYPASS]),
		.lowCnt(ch0Counts_q[`LOW_MSB:`LOW_LSB]), .highCnt(ch0Counts_q[`HIGH_MSB:`HIGH_LSB]),
		.dccOn(~ch0Fix_q[`BIT_DUTY_FIX_DISABLE]),
		.syncReq(syncAll), .delayCyc(delay0),
		.outLvl(c0Lvl), .outRise(), .outFall()
	);

	// channel 1 single stage
	div_stage u_ch1 (
		.core_clk(core_clk), .resetn(resetn),
		.inLvl(dist_q), .inRise(inRise), .inFall(inFall),
		.bypass(ch1Phase_q[`BIT_CH01_BYPASS]),
		.lowCnt(ch1Counts_q[`LOW_MSB:`LOW_LSB]), .highCnt(ch1Counts_q[`HIGH_MSB:`HIGH_LSB]),
		.dccOn(~ch1Fix_q[`BIT_DUTY_FIX_DISABLE]),
		.syncReq(syncAll), .delayCyc(delay1),
		.outLvl(c1Lvl), .outRise(), .outFall()
	);

	// channel 2: first stage fed by the distribution clock
	div_stage u_ch2s1 (
		.core_clk(core_clk), .resetn(resetn),
		.inLvl(dist_q), .inRise(inRise), .inFall(inFall),
		.bypass(ch2Byp_q[`BIT_STAGE1_BYPASS]),
		.lowCnt(ch2S1_q[`LOW_MSB:`LOW_LSB]), .highCnt(ch2S1_q[`HIGH_MSB:`HIGH_LSB]),
		.dccOn(~ch2Fix_q[`BIT_DUTY_FIX_DISABLE]),
		.syncReq(syncAll), .delayCyc(5'h00),
		.outLvl(s21Lvl), .outRise(s21Rise), .outFall(s21Fall)
	);

	// channel 2: second stage counts first-stage edges, ratios multiply
	div_stage u_ch2s2 (
		.core_clk(core_clk), .resetn(resetn),
		.inLvl(s21Lvl), .inRise(s21Rise), .inFall(s21Fall),
		.bypass(ch2Byp_q[`BIT_STAGE2_BYPASS]),
		.lowCnt(ch2S2_q[`LOW_MSB:`LOW_LSB]), .highCnt(ch2S2_q[`HIGH_MSB:`HIGH_LSB]),
		.dccOn(~ch2Fix_q[`BIT_DUTY_FIX_DISABLE]),
		.syncReq(syncAll), .delayCyc(5'h00),
		.outLvl(c2Lvl), .outRise(), .outFall()
	);

	// channel 3: first stage
	div_stage u_ch3s1 (
		.core_clk(core_clk), .resetn(resetn),
		.inLvl(dist_q), .inRise(inRise), .inFall(inFall),
		.bypass(ch3Byp_q[`BIT_STAGE1_BYPASS]),
		.lowCnt(ch3S1_q[`LOW_MSB:`LOW_LSB]), .highCnt(ch3S1_q[`HIGH_MSB:`HIGH_LSB]),
		.dccOn(~ch3Fix_q[`BIT_DUTY_FIX_DISABLE]),
		.syncReq(syncAll), .delayCyc(5'h00),
		.outLvl(s31Lvl), .outRise(s31Rise), .outFall(s31Fall)
	);

	// channel 3: second stage
	div_stage u_ch3s2 (
		.core_clk(core_clk), .resetn(resetn),
		.inLvl(s31Lvl), .inRise(s31Rise), .inFall(s31Fall),
		.bypass(ch3Byp_q[`BIT_STAGE2_BYPASS]),
		.lowCnt(ch3S2_q[`LOW_MSB:`LOW_LSB]), .highCnt(ch3S2_q[`HIGH_MSB:`HIGH_LSB]),
		.dccOn(~ch3Fix_q[`BIT_DUTY_FIX_DISABLE]),
		.syncReq(syncAll), .delayCyc(5'h00),
		.outLvl(c3Lvl), .outRise(), .outFall()
	);

	// live output levels for software
	assign statusBits = {c3Lvl, c2Lvl, c1Lvl, c0Lvl};

	// output drivers; B halves stay low until enabled
	assign ch0Out = c0Lvl;
	assign ch1Out = c1Lvl;
	assign ch2Out = c2Lvl;
	assign ch2OutA = c2Lvl;
	assign ch2OutB = c2Lvl & outEn_q[`BIT_CH2_B_ENABLE];
	assign ch3Out = c3Lvl;
	assign ch3OutA = c3Lvl;
	assign ch3OutB = c3Lvl & outEn_q[`BIT_CH3_B_ENABLE];
endmodule // channel_clock_dividers

// ---- hw/chan_div_map.svh ----
/*
 * Register indices, field positions and reset values of the channel
 * clock dividers. Assumes an includer that uses these names only.
 */
`ifndef CHAN_DIV_MAP_SVH
`define CHAN_DIV_MAP_SVH

// register indices; byte address is four times the index
`define IDX_CH0_CYCLE_COUNTS 9'h190
`define IDX_CH0_PHASE_SETUP 9'h191
`define IDX_CH0_DUTY_FIX 9'h192
`define IDX_CH1_CYCLE_COUNTS 9'h196
`define IDX_CH1_PHASE_SETUP 9'h197
`define IDX_CH1_DUTY_FIX 9'h198
`define IDX_CH2_STAGE1_COUNTS 9'h199
`define IDX_CH2_STAGE2_COUNTS 9'h19B
`define IDX_CH2_BYPASS_CTRL 9'h19C
`define IDX_CH2_DUTY_FIX_CTRL 9'h19D
`define IDX_CH3_STAGE1_COUNTS 9'h19E
`define IDX_CH3_STAGE2_COUNTS 9'h1A0
`define IDX_CH3_BYPASS_CTRL 9'h1A1
`define IDX_CH3_DUTY_FIX_CTRL 9'h1A2
`define IDX_OUT_ENABLE 9'h1A4
`define IDX_STATUS 9'h1A5
`define IDX_SYNC_CTRL 9'h1A6

// field positions
`define LOW_MSB 7
`define LOW_LSB 4
`define HIGH_MSB 3
`define HIGH_LSB 0
`define BIT_CH01_BYPASS 7
`define BIT_START_HIGH 4
`define PO_MSB 3
`define PO_LSB 0
`define BIT_STAGE1_BYPASS 4
`define BIT_STAGE2_BYPASS 5
`define BIT_DUTY_FIX_DISABLE 0
`define BIT_CH2_B_ENABLE 0
`define BIT_CH3_B_ENABLE 1
`define BIT_SYNC_GO 0

// reset values
`define RST_REG8 8'h00

// bus answer for an unmapped read
`define UNMAPPED_DATA 32'h00000000

`endif

// ---- hw/chan_div_pkg.sv ----
/*
 * Types shared by the channel divider design.
 * Assumes chan_div_map.svh carries all numeric constants.
 */
package chan_div_pkg;

	// state of one divider stage
	typedef enum logic [1:0] {
		ST_WAIT,
		ST_HIGH,
		ST_LOW
	} stage_state_t;

	typedef logic [7:0] reg8_t;

endpackage

// ---- sim/dist_clk_source.sv ----
/* distribution clock source: free-running level with set high and low spans.
   assumes spans of one core cycle or more, changed only between edges. */
`timescale 1ns/100ps
module dist_clk_source (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [3:0] hiCyc,
	input wire logic [3:0] loCyc,
	output logic distClk_q
);
	logic [3:0] cnt_q;
	// level flips when the current span runs out
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			distClk_q <= 1'b0;
			cnt_q <= 4'h0;
		end else if (cnt_q + 4'h1 >= (distClk_q ? hiCyc : loCyc)) begin
			distClk_q <= !distClk_q;
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule // dist_clk_source

// ---- sim/chan_div_monitor.sv ----
/* port checker of the channel dividers: bus timing, split outputs, sync.
   assumes one clock domain and ports of the top module only. */
`timescale 1ns/100ps
`include "chan_div_map.svh"
module chan_div_monitor (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic syncPulse,
	input wire logic [10:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	input wire logic [31:0] avsReadData,
	input wire logic avsWaitRequest,
	input wire logic ch0Out,
	input wire logic ch1Out,
	input wire logic ch2Out,
	input wire logic ch2OutA,
	input wire logic ch2OutB,
	input wire logic ch3Out,
	input wire logic ch3OutA,
	input wire logic ch3OutB
);
	logic req;
	logic [1:0] bEn_q;
	assign req = avsRead | avsWrite;
	// mirror of the B-output enable bits
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) bEn_q <= 2'h0;
		else if (avsWrite && !avsWaitRequest && avsByteEnable[0]
			&& avsAddress[10:2] == `IDX_OUT_ENABLE) bEn_q <= avsWriteData[1:0];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_wait_first: assert property (req && !$past(req) |-> avsWaitRequest)
		else $error("no wait cycle at request start");
	a_wait_one: assert property (req && avsWaitRequest |=> !avsWaitRequest)
		else $error("more than one wait cycle");
	a_idle_nowait: assert property (!req |-> !avsWaitRequest)
		else $error("waitrequest without request");
	a_read_upper: assert property (avsRead && !avsWaitRequest |-> avsReadData[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_unmapped_zero: assert property (avsRead && !avsWaitRequest
		&& avsAddress[10:2] < `IDX_CH0_CYCLE_COUNTS |-> avsReadData == `UNMAPPED_DATA)
		else $error("unmapped read not zero");
	a_split_same: assert property (ch2OutA == ch2Out)
		else $error("A output differs from channel");
	a_b_gated: assert property (!bEn_q[0] |-> !ch2OutB)
		else $error("B output on while disabled");
	a_b_follow: assert property (bEn_q[0] |-> ch2OutB == ch2Out)
		else $error("B output not following channel");
	a_a3_same: assert property (ch3OutA == ch3Out)
		else $error("channel 3 A output differs from channel");
	a_b3_gated: assert property (!bEn_q[1] |-> !ch3OutB)
		else $error("channel 3 B output on while disabled");
	a_b3_follow: assert property (bEn_q[1] |-> ch3OutB == ch3Out)
		else $error("channel 3 B output not following channel");
	a_reset_quiet: assert property ($rose(resetn) |-> !ch0Out && !ch1Out && !ch2Out && !ch2OutB
		&& !ch3Out && !ch3OutB)
		else $error("output active right after reset");
	a_sync_clear: assert property (syncPulse |-> ##[1:2] !ch0Out && !ch1Out)
		else $error("sync did not clear outputs");
	c_out_enable: cover property (avsWrite && !avsWaitRequest && avsAddress[10:2] == `IDX_OUT_ENABLE);
	c_sync: cover property (syncPulse);
	c_b_rise: cover property ($rose(ch2OutB));
endmodule // chan_div_monitor

bind channel_clock_dividers chan_div_monitor mon (.core_clk(core_clk), .resetn(resetn),
	.syncPulse(syncPulse), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
	.avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
	.avsWaitRequest(avsWaitRequest), .ch0Out(ch0Out), .ch1Out(ch1Out), .ch2Out(ch2Out),
	.ch2OutA(ch2OutA), .ch2OutB(ch2OutB), .ch3Out(ch3Out), .ch3OutA(ch3OutA),
	.ch3OutB(ch3OutB));

// ---- sim/channel_clock_dividers_tb.sv ----
/* self-checking bench of the channel dividers: registers, ratios, offsets, duty.
   assumes the distribution clock source model and a 10 MHz core clock. */
`timescale 1ns/100ps
`include "chan_div_map.svh"
module channel_clock_dividers_tb
	import chan_div_pkg::*;
;
	localparam logic [8:0] RIDX [15] = '{`IDX_CH0_CYCLE_COUNTS, `IDX_CH0_PHASE_SETUP,
		`IDX_CH0_DUTY_FIX, `IDX_CH1_CYCLE_COUNTS, `IDX_CH1_PHASE_SETUP, `IDX_CH1_DUTY_FIX,
		`IDX_CH2_STAGE1_COUNTS, `IDX_CH2_STAGE2_COUNTS, `IDX_CH2_BYPASS_CTRL,
		`IDX_CH2_DUTY_FIX_CTRL, `IDX_CH3_STAGE1_COUNTS, `IDX_CH3_STAGE2_COUNTS,
		`IDX_CH3_BYPASS_CTRL, `IDX_CH3_DUTY_FIX_CTRL, `IDX_OUT_ENABLE};
	localparam logic [7:0] PS_TAB [4] = '{8'h05, 8'h0F, 8'h10, 8'h13};
	localparam int DH [3] = '{2, 2, 3};
	localparam int DL [3] = '{4, 3, 1};
	logic core_clk = 1'b0, resetn = 1'b0, syncPulse = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
	logic [10:0] avsAddress = 11'h000;
	logic [31:0] avsWriteData = 32'h00000000, avsReadData, rng = 32'h000124F2;
	logic [3:0] hiCyc = 4'h2, loCyc = 4'h2;
	logic avsWaitRequest, distClkIn, ch0Out, ch1Out, ch2Out, ch2OutA, ch2OutB, ch3Out;
	logic [4:0] outs, prev;
	int nErrors = 0, samplesChecked = 0, cyc = 0;
	int first [5];
	assign outs = {ch3Out, ch2OutB, ch2Out, ch1Out, ch0Out};
	always #50 core_clk = !core_clk;
	channel_clock_dividers uut (.core_clk(core_clk), .resetn(resetn), .distClkIn(distClkIn),
		.syncPulse(syncPulse), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(4'hF), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .ch0Out(ch0Out), .ch1Out(ch1Out), .ch2Out(ch2Out),
		.ch2OutA(ch2OutA), .ch2OutB(ch2OutB), .ch3Out(ch3Out), .ch3OutA(), .ch3OutB());
	dist_clk_source src (.core_clk(core_clk), .resetn(resetn), .hiCyc(hiCyc), .loCyc(loCyc),
		.distClk_q(distClkIn));
	// cycle count and first rise of each output after a sync pulse
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		prev <= outs;
		for (int i = 0; i < 5; i++) begin
			if (syncPulse) first[i] <= -1;
			else if (outs[i] && !prev[i] && first[i] < 0) first[i] <= cyc;
		end
	end
	function logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	// model of the delay in input cycles
	function automatic int expDelay(input logic [7:0] ps, input int m);
		int phi;
		phi = 16 * ps[4] + ps[3:0];
		return (phi <= 15) ? phi : phi - 16 + m + 1;
	endfunction
	// one bus cycle, entered right after a rising edge
	task automatic busCyc(input logic rd, input logic [8:0] idx, input logic [7:0] wd,
		output logic [31:0] rdat);
		avsRead <= rd;
		avsWrite <= !rd;
		avsAddress <= {idx, 2'h0};
		avsWriteData <= {24'h000000, wd};
		// only the watchdog ends a wait that never finishes
		do begin
			@(negedge core_clk);
		end while (avsWaitRequest !== 1'b0);
		@(posedge core_clk);
		rdat = avsReadData; // taken at the edge that sees waitrequest low
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [8:0] idx, input logic [7:0] wd);
		logic [31:0] dummy;
		busCyc(1'b0, idx, wd, dummy);
	endtask
	task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			nErrors++;
			$display("[FAIL] t=%0t register got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chkCyc(input int got, input int exp);
		samplesChecked++;
		if (got != exp) begin
			nErrors++;
			$display("[FAIL] t=%0t cycles got %0d want %0d", $time, got, exp);
		end
	endtask
	task automatic waitLvl(input int ch, input logic lvl);
		int n;
		n = 0;
		while (outs[ch] !== lvl && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 3000) chkCyc(n, 0);
	endtask
	// period and high time of one output, in core cycles
	task automatic measure(input int ch, output int per, output int hi);
		int t0;
		waitLvl(ch, 1'b0);
		waitLvl(ch, 1'b1);
		t0 = cyc;
		waitLvl(ch, 1'b0);
		hi = cyc - t0;
		waitLvl(ch, 1'b1);
		per = cyc - t0;
		@(posedge core_clk);
	endtask
	task automatic testDone();
		$display("checks %0d mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		#(100 * 40000);
		nErrors++;
		$display("[FAIL] t=%0t watchdog expired", $time);
		testDone();
	end
	// main sequence
	initial begin
		int per, hi, k;
		logic [31:0] d, r;
		logic [3:0] n4, m4;
		logic [8:0] b;
		logic [7:0] shadow [$];
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		foreach (RIDX[i]) begin
			busCyc(1'b1, RIDX[i], 8'h00, d);
			chkReg(d, 32'h00000000);
			r = xs();
			shadow.push_back(r[7:0]);
			wr(RIDX[i], r[7:0]);
			busCyc(1'b1, RIDX[i], 8'h00, d);
			chkReg(d, {24'h000000, shadow.pop_front()});
		end
		busCyc(1'b1, 9'h000, 8'h00, d);
		chkReg(d, `UNMAPPED_DATA);
		$display("test registers done");
		wr(`IDX_CH0_PHASE_SETUP, 8'h00);
		wr(`IDX_CH0_DUTY_FIX, 8'h01);
		for (int j = 0; j < 3; j++) begin
			r = xs();
			n4 = {2'h0, r[1:0]};
			m4 = {2'h0, r[3:2]};
			wr(`IDX_CH0_CYCLE_COUNTS, {m4, n4});
			wr(`IDX_SYNC_CTRL, 8'h01);
			measure(0, per, hi);
			chkCyc(per, (n4 + m4 + 2) * 4);
			chkCyc(hi, (n4 + 1) * 4);
		end
		wr(`IDX_CH0_DUTY_FIX, 8'h00);
		wr(`IDX_CH0_CYCLE_COUNTS, 8'h21);
		wr(`IDX_SYNC_CTRL, 8'h01);
		measure(0, per, hi);
		chkCyc(hi, 10);
		chkCyc(per, 20);
		$display("test ratio and correction done");
		wr(`IDX_CH0_DUTY_FIX, 8'h01);
		wr(`IDX_CH1_DUTY_FIX, 8'h01);
		wr(`IDX_CH1_CYCLE_COUNTS, 8'h21);
		foreach (PS_TAB[i]) begin
			wr(`IDX_CH1_PHASE_SETUP, PS_TAB[i]);
			syncPulse <= 1'b1;
			@(posedge core_clk);
			syncPulse <= 1'b0;
			measure(1, per, hi);
			chkCyc(first[1] - first[0], expDelay(PS_TAB[i], 2) * 4);
		end
		$display("test offsets done");
		for (int c = 0; c < 2; c++) begin
			b = 9'(5 * c);
			wr(`IDX_CH2_DUTY_FIX_CTRL + b, 8'h01);
			wr(`IDX_CH2_STAGE1_COUNTS + b, 8'h10);
			wr(`IDX_CH2_STAGE2_COUNTS + b, 8'h11);
			for (int j = 0; j < 2; j++) begin
				wr(`IDX_CH2_BYPASS_CTRL + b, j ? 8'h20 : 8'h00);
				wr(`IDX_SYNC_CTRL, 8'h01);
				measure(c ? 4 : 2, per, hi);
				chkCyc(per, j ? 12 : 48);
				chkCyc(hi, j ? 4 : 24);
			end
		end
		$display("test cascade done");
		wr(`IDX_CH2_BYPASS_CTRL, 8'h30);
		foreach (DH[i]) begin
			hiCyc <= 4'(DH[i]);
			loCyc <= 4'(DL[i]);
			// no sync here: it would force a short low into the bypassed path
			repeat (4) @(posedge core_clk);
			measure(2, per, hi);
			chkCyc(hi, DH[i]);
			chkCyc(per, DH[i] + DL[i]);
		end
		// a held sync keeps every output low, so status reads zero
		syncPulse <= 1'b1;
		repeat (3) @(posedge core_clk);
		busCyc(1'b1, `IDX_STATUS, 8'h00, d);
		chkReg(d, 32'h00000000);
		syncPulse <= 1'b0;
		@(posedge core_clk);
		wr(`IDX_OUT_ENABLE, 8'h00);
		k = 0;
		repeat (20) begin
			@(negedge core_clk);
			if (ch2OutB !== 1'b0) k++;
		end
		@(posedge core_clk);
		chkCyc(k, 0);
		wr(`IDX_OUT_ENABLE, 8'h03);
		measure(3, per, hi);
		chkCyc(hi, 3);
		$display("test duty and split outputs done");
		testDone();
	end
endmodule // channel_clock_dividers_tb
